// ===== hdl/dspace_defs.svh
`ifndef DSPACE_DEFS_SVH
`define DSPACE_DEFS_SVH

// Data-space address map
`define BANK_HI        8'h3f
`define WIN_LO         8'h40
`define WIN_HI         8'h7f
`define IDX_X          8'h80
`define IDX_Y          8'h81
`define SHORT_V        8'h82
`define SHORT_W        8'h83
`define RAM_LO         8'h84
`define RAM_HI         8'hbf
`define PORT_DATA_LO   8'hc0
`define PORT_DATA_HI   8'hc2
`define PORT_DIR_LO    8'hc4
`define PORT_DIR_HI    8'hc6
`define INT_OPT        8'hc8
`define PAGE_ADDR      8'hc9
`define PORT_OPT_LO    8'hcc
`define PORT_OPT_HI    8'hce
`define ADC_DATA       8'hd0
`define ADC_CTRL       8'hd1
`define TMR_PSC        8'hd2
`define TMR_CNT        8'hd3
`define TMR_SC         8'hd4
`define MISC_LO        8'hd5
`define MISC_HI        8'hdd
`define BANK_SEL       8'he8
`define EE_CTRL        8'hea
`define ACC_ADDR       8'hff

// Field layout and sizes
`define WIN_OFS_BITS   6
`define PAGE_BITS      6
`define PC_BITS        12
`define STACK_DEPTH    6
`define RAM_BYTES      60
`define PC_RESET       12'h000
`define READ_ZERO      8'h00

`endif

// ===== hdl/dspace_pkg.sv
`include "dspace_defs.svh"

package dspace_pkg;

    typedef enum logic [4:0] {
        SLOT_NONE      = 5'h00,
        SLOT_BANK      = 5'h01,
        SLOT_WINDOW    = 5'h02,
        SLOT_IDX_X     = 5'h03,
        SLOT_IDX_Y     = 5'h04,
        SLOT_SHORT_V   = 5'h05,
        SLOT_SHORT_W   = 5'h06,
        SLOT_RAM       = 5'h07,
        SLOT_PORT_DATA = 5'h08,
        SLOT_PORT_DIR  = 5'h09,
        SLOT_INT_OPT   = 5'h0a,
        SLOT_PAGE      = 5'h0b,
        SLOT_PORT_OPT  = 5'h0c,
        SLOT_ADC_DATA  = 5'h0d,
        SLOT_ADC_CTRL  = 5'h0e,
        SLOT_TMR_PSC   = 5'h0f,
        SLOT_TMR_CNT   = 5'h10,
        SLOT_TMR_SC    = 5'h11,
        SLOT_PERIPH    = 5'h12,
        SLOT_ACC       = 5'h13
    } slot_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } access_state_t;

    typedef struct packed {
        access_state_t                        state;
        slot_t                                slot;
        logic                                 is_read;
        logic [`PAGE_BITS-1:0]                page;
        logic [`RAM_BYTES-1:0][7:0]           ram;
        logic [5:0]                           ram_idx;
        logic [`PC_BITS-1:0]                  pm_addr;
        logic [7:0]                           rdata;
        logic                                 rdata_valid;
        logic                                 busy;
        logic                                 slot_rd;
        logic                                 slot_wr;
        logic [7:0]                           slot_addr;
        logic [7:0]                           slot_wdata;
        logic [`PC_BITS-1:0]                  pc;
        logic                                 nmi_s1;
        logic                                 nmi_s2;
        logic                                 nmi_s3;
        logic                                 nmi_pending;
        logic                                 rst_s1;
        logic                                 rst_s2;
        logic                                 restart;
        logic                                 test_s1;
        logic                                 test_s2;
        logic                                 prog_mode;
        logic                                 ext_pending;
        logic                                 ext_valid;
        logic [7:0]                           ext_data;
    } dspace_state_t;

endpackage : dspace_pkg

// ===== hdl/return_stack.sv
`include "dspace_defs.svh"

module return_stack #(
    parameter int WIDTH = `PC_BITS,
    parameter int DEPTH = `STACK_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] entry;
    } stack_state_t;

    stack_state_t st_reg;
    stack_state_t st_next;

    // Push shifts down and loses the oldest entry; pop shifts up
    always_comb begin
        st_next = st_reg;
        if (!resetn) begin
            st_next = '0;
        end else if (push) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                st_next.entry[i] = st_reg.entry[i-1];
            end
            st_next.entry[0] = push_data; // RULE7
        end else if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_next.entry[i] = st_reg.entry[i+1];
            end
            st_next.entry[DEPTH-1] = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign top_data = st_reg.entry[0];

    property p_push_top;
        @(posedge clk) disable iff (!resetn)
        push |=> top_data == $past(push_data);
    endproperty
    a_push_top: assert property (p_push_top) else $error("Pushed value not on top"); // RULE7

    property p_push_pop;
        @(posedge clk) disable iff (!resetn)
        push ##1 (pop && !push) |=> top_data == $past(st_reg.entry[1], 1);
    endproperty
    a_push_pop: assert property (p_push_pop) else $error("Pop did not restore entry"); // RULE7

endmodule : return_stack

// ===== hdl/data_space_map_rom_window.sv
`include "dspace_defs.svh"

// What this block does
// [RULE1] Addresses 40h to 7Fh read bytes from program memory.
// [RULE2] Program address is page register above the low six address bits.
// [RULE3] Page register at C9h takes whole-byte writes only; software never reads it. A read of C9h here is accepted and returns 00h.
// [RULE4] Page register is not cleared by reset; software loads it first.
// [RULE5] Only six low page bits exist and form the upper program address.
// [RULE6] Program counter is 12 bits wide.
// [RULE7] Return stack holds six 12-bit return addresses.
// [RULE8] Addresses 00h to 3Fh go to the selected 64-byte bank.
// [RULE9] Sixty bytes of general RAM sit beside the banked area.
// [RULE10] Index registers decode at 80h and 81h, short registers follow.
// [RULE11] Port direction registers decode at C4h to C6h.
// [RULE12] Port option registers decode at CCh to CEh.
// [RULE13] Converter result at D0h, converter control at D1h.
// [RULE14] Timer prescaler, counter and status decode at D2h to D4h.
// [RULE15] Accumulator is reachable at data address FFh.
// [RULE16] Falling edge on the interrupt pin raises a non-maskable request.
// [RULE17] Low level on the reset pin restarts the controller.
// [RULE18] Test pin high during reset enters memory programming mode.
// [RULE19] Readout protection blocks external reading of program memory.
// [RULE20] Upper two page bits written are dropped.
module data_space_map_rom_window
    import dspace_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    core_rd,
    input  wire logic                    core_wr,
    input  wire logic                    core_bit_op,
    input  wire logic [7:0]              core_addr,
    input  wire logic [7:0]              core_wdata,
    output logic      [7:0]              core_rdata,
    output logic                         core_rdata_valid,
    output logic                         core_busy,
    output dspace_pkg::slot_t            slot_sel,
    output logic [7:0]                   slot_addr,
    output logic [7:0]                   slot_wdata,
    output logic                         slot_rd,
    output logic                         slot_wr,
    input  wire logic [7:0]              slot_rdata,
    output logic [`PC_BITS-1:0]          pm_read_addr,
    input  wire logic [7:0]              pm_read_data,
    input  wire logic                    pc_step,
    input  wire logic                    pc_jump,
    input  wire logic                    call_req,
    input  wire logic                    ret_req,
    input  wire logic [`PC_BITS-1:0]     jump_target,
    output logic [`PC_BITS-1:0]          prog_counter,
    input  wire logic                    nmi_pin_n,
    input  wire logic                    nmi_ack,
    output logic                         nmi_request,
    input  wire logic                    reset_pin_n,
    output logic                         core_restart,
    input  wire logic                    test_pin_high,
    output logic                         prog_mode,
    input  wire logic                    readout_protect,
    input  wire logic                    ext_rd_req,
    input  wire logic [`PC_BITS-1:0]     ext_rd_addr,
    output logic [7:0]                   ext_rd_data,
    output logic                         ext_rd_valid
);
    import dspace_pkg::*;

    dspace_state_t       st_reg;
    dspace_state_t       st_next;
    logic [`PC_BITS-1:0] stack_top;
    logic                take;
    logic                push;
    logic                pop;

    function automatic slot_t decode_slot(input logic [7:0] a);
        slot_t s;
        s = SLOT_NONE;
        if (a <= `BANK_HI) begin
            s = SLOT_BANK; // RULE8
        end else if (a <= `WIN_HI) begin
            s = SLOT_WINDOW; // RULE1
        end else if (a == `IDX_X) begin
            s = SLOT_IDX_X; // RULE10
        end else if (a == `IDX_Y) begin
            s = SLOT_IDX_Y; // RULE10
        end else if (a == `SHORT_V) begin
            s = SLOT_SHORT_V;
        end else if (a == `SHORT_W) begin
            s = SLOT_SHORT_W;
        end else if (a >= `RAM_LO && a <= `RAM_HI) begin
            s = SLOT_RAM; // RULE9
        end else if (a >= `PORT_DATA_LO && a <= `PORT_DATA_HI) begin
            s = SLOT_PORT_DATA;
        end else if (a >= `PORT_DIR_LO && a <= `PORT_DIR_HI) begin
            s = SLOT_PORT_DIR; // RULE11
        end else if (a == `INT_OPT) begin
            s = SLOT_INT_OPT;
        end else if (a == `PAGE_ADDR) begin
            s = SLOT_PAGE; // RULE3
        end else if (a >= `PORT_OPT_LO && a <= `PORT_OPT_HI) begin
            s = SLOT_PORT_OPT; // RULE12
        end else if (a == `ADC_DATA) begin
            s = SLOT_ADC_DATA; // RULE13
        end else if (a == `ADC_CTRL) begin
            s = SLOT_ADC_CTRL; // RULE13
        end else if (a == `TMR_PSC) begin
            s = SLOT_TMR_PSC; // RULE14
        end else if (a == `TMR_CNT) begin
            s = SLOT_TMR_CNT; // RULE14
        end else if (a == `TMR_SC) begin
            s = SLOT_TMR_SC; // RULE14
        end else if ((a >= `MISC_LO && a <= `MISC_HI) || a == `BANK_SEL || a == `EE_CTRL) begin
            s = SLOT_PERIPH;
        end else if (a == `ACC_ADDR) begin
            s = SLOT_ACC; // RULE15
        end
        return s;
    endfunction : decode_slot

    // Slots served outside this block through the slot strobes
    function automatic logic is_external(input slot_t s);
        return !(s inside {SLOT_NONE, SLOT_WINDOW, SLOT_RAM, SLOT_PAGE});
    endfunction : is_external

    function automatic logic [5:0] ram_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - `RAM_LO;
        return d[5:0];
    endfunction : ram_index

    assign take = (st_reg.state == ST_IDLE) && !st_reg.prog_mode && !st_reg.restart
                  && (core_rd || core_wr);
    assign push = call_req && !st_reg.restart;
    assign pop  = ret_req && !call_req && !st_reg.restart;

    return_stack #(
        .WIDTH (`PC_BITS),
        .DEPTH (`STACK_DEPTH)
    ) u_stack (
        .clk       (clk),
        .resetn    (resetn),
        .push      (push),
        .pop       (pop),
        .push_data (st_reg.pc + `PC_BITS'(1)),
        .top_data  (stack_top)
    );

    always_comb begin
        slot_t s;
        s = decode_slot(core_addr);
        st_next = st_reg;
        st_next.rdata_valid = 1'b0;
        st_next.slot_rd = 1'b0;
        st_next.slot_wr = 1'b0;
        st_next.ext_valid = 1'b0;
        // Pin synchronisers
        st_next.nmi_s1 = nmi_pin_n;
        st_next.nmi_s2 = st_reg.nmi_s1;
        st_next.nmi_s3 = st_reg.nmi_s2;
        st_next.rst_s1 = reset_pin_n;
        st_next.rst_s2 = st_reg.rst_s1;
        st_next.test_s1 = test_pin_high;
        st_next.test_s2 = st_reg.test_s1;
        st_next.restart = !st_reg.rst_s2; // RULE17
        if (st_reg.restart) begin
            st_next.prog_mode = st_reg.test_s2; // RULE18
        end
        // Non-maskable request, a new edge wins over the acknowledge
        if (st_reg.nmi_s3 && !st_reg.nmi_s2) begin
            st_next.nmi_pending = 1'b1; // RULE16
        end else if (nmi_ack) begin
            st_next.nmi_pending = 1'b0;
        end
        // Program counter and return stack
        if (st_reg.restart) begin
            st_next.pc = `PC_RESET; // RULE17
        end else if (call_req || pc_jump) begin
            st_next.pc = jump_target;
        end else if (ret_req) begin
            st_next.pc = stack_top; // RULE7
        end else if (pc_step) begin
            st_next.pc = st_reg.pc + `PC_BITS'(1); // RULE6
        end
        // External readout in programming mode
        if (st_reg.ext_pending) begin
            st_next.ext_pending = 1'b0;
            st_next.ext_valid = 1'b1;
            st_next.ext_data = readout_protect ? `READ_ZERO : pm_read_data; // RULE19
        end else if (st_reg.prog_mode && ext_rd_req) begin
            st_next.ext_pending = 1'b1;
            st_next.pm_addr = ext_rd_addr;
        end
        // Core data-space access
        unique case (st_reg.state)
            ST_IDLE: begin
                st_next.busy = 1'b0;
                if (take) begin
                    st_next.state = ST_BUSY;
                    st_next.busy = 1'b1;
                    st_next.slot = s;
                    st_next.is_read = core_rd;
                    st_next.slot_addr = core_addr;
                    st_next.slot_wdata = core_wdata;
                    st_next.slot_rd = core_rd && is_external(s);
                    st_next.slot_wr = !core_rd && is_external(s);
                    if (s == SLOT_WINDOW) begin
                        st_next.pm_addr = {st_reg.page, core_addr[`WIN_OFS_BITS-1:0]}; // RULE2
                    end
                    if (s == SLOT_RAM) begin
                        st_next.ram_idx = ram_index(core_addr); // RULE9
                        if (!core_rd) begin
                            st_next.ram[ram_index(core_addr)] = core_wdata;
                        end
                    end
                    if (s == SLOT_PAGE && !core_rd && !core_bit_op) begin
                        st_next.page = core_wdata[`PAGE_BITS-1:0]; // RULE3 RULE5 RULE20
                    end
                end
            end
            ST_BUSY: begin
                st_next.state = ST_IDLE;
                st_next.busy = 1'b0;
                if (st_reg.is_read) begin
                    st_next.rdata_valid = 1'b1;
                    if (st_reg.slot == SLOT_WINDOW) begin
                        st_next.rdata = pm_read_data; // RULE1
                    end else if (st_reg.slot == SLOT_RAM) begin
                        st_next.rdata = st_reg.ram[st_reg.ram_idx];
                    end else if (is_external(st_reg.slot)) begin
                        st_next.rdata = slot_rdata;
                    end else begin
                        st_next.rdata = `READ_ZERO; // RULE3
                    end
                end
            end
        endcase
        if (!resetn) begin
            st_next = '0;
            st_next.state = ST_IDLE;
            st_next.slot = SLOT_NONE;
            st_next.pc = `PC_RESET;
            st_next.rst_s1 = 1'b1;
            st_next.rst_s2 = 1'b1;
            st_next.nmi_s1 = 1'b1;
            st_next.nmi_s2 = 1'b1;
            st_next.nmi_s3 = 1'b1;
            st_next.page = st_reg.page; // RULE4
            st_next.ram = st_reg.ram;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign core_rdata       = st_reg.rdata;
    assign core_rdata_valid = st_reg.rdata_valid;
    assign core_busy        = st_reg.busy;
    assign slot_sel         = st_reg.slot;
    assign slot_addr        = st_reg.slot_addr;
    assign slot_wdata       = st_reg.slot_wdata;
    assign slot_rd          = st_reg.slot_rd;
    assign slot_wr          = st_reg.slot_wr;
    assign pm_read_addr     = st_reg.pm_addr;
    assign prog_counter     = st_reg.pc;
    assign nmi_request      = st_reg.nmi_pending;
    assign core_restart     = st_reg.restart;
    assign prog_mode        = st_reg.prog_mode;
    assign ext_rd_data      = st_reg.ext_data;
    assign ext_rd_valid     = st_reg.ext_valid;

    property p_win_addr;
        @(posedge clk) disable iff (!resetn)
        take && core_rd && core_addr inside {[`WIN_LO:`WIN_HI]}
            |=> pm_read_addr == {$past(st_reg.page), $past(core_addr[5:0])};
    endproperty
    a_win_addr: assert property (p_win_addr) else $error("Window address wrong"); // RULE2

    property p_win_data;
        @(posedge clk) disable iff (!resetn)
        take && core_rd && core_addr inside {[`WIN_LO:`WIN_HI]}
            |=> ##1 core_rdata_valid && core_rdata == $past(pm_read_data);
    endproperty
    a_win_data: assert property (p_win_data) else $error("Window data wrong"); // RULE1

    property p_page_bitop;
        @(posedge clk) disable iff (!resetn)
        take && core_wr && !core_rd && core_bit_op && core_addr == `PAGE_ADDR
            |=> $stable(st_reg.page);
    endproperty
    a_page_bitop: assert property (p_page_bitop) else $error("Bit op changed page"); // RULE3

    property p_page_write;
        @(posedge clk) disable iff (!resetn)
        take && !core_rd && !core_bit_op && core_addr == `PAGE_ADDR
            |=> st_reg.page == $past(core_wdata[5:0]);
    endproperty
    a_page_write: assert property (p_page_write) else $error("Page not loaded"); // RULE20

    property p_pc_step;
        @(posedge clk) disable iff (!resetn)
        pc_step && !pc_jump && !call_req && !ret_req && !st_reg.restart
            |=> prog_counter == $past(prog_counter) + 12'h001;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("Counter step wrong"); // RULE6

    property p_bank;
        @(posedge clk) disable iff (!resetn)
        take && core_rd && core_addr <= `BANK_HI
            |=> slot_sel == SLOT_BANK && slot_rd && slot_addr == $past(core_addr);
    endproperty
    a_bank: assert property (p_bank) else $error("Bank slot wrong"); // RULE8

    property p_ram;
        @(posedge clk) disable iff (!resetn)
        take && !core_rd && core_addr inside {[`RAM_LO:`RAM_HI]}
            |=> st_reg.ram[st_reg.ram_idx] == $past(core_wdata) && !slot_wr;
    endproperty
    a_ram: assert property (p_ram) else $error("RAM write lost"); // RULE9

    property p_acc;
        @(posedge clk) disable iff (!resetn)
        take && core_addr == `ACC_ADDR |=> slot_sel == SLOT_ACC;
    endproperty
    a_acc: assert property (p_acc) else $error("Accumulator slot wrong"); // RULE15

    property p_nmi;
        @(posedge clk) disable iff (!resetn)
        $fell(st_reg.nmi_s2) |=> ##1 nmi_request;
    endproperty
    a_nmi: assert property (p_nmi) else $error("Edge request lost"); // RULE16

    property p_prog;
        @(posedge clk) disable iff (!resetn)
        st_reg.restart && st_reg.test_s2 |=> prog_mode;
    endproperty
    a_prog: assert property (p_prog) else $error("Programming mode missed"); // RULE18

    property p_protect;
        @(posedge clk) disable iff (!resetn)
        st_reg.ext_pending && readout_protect |=> ext_rd_valid && ext_rd_data == 8'h00;
    endproperty
    a_protect: assert property (p_protect) else $error("Protected data leaked"); // RULE19

    c_win_read: cover property (@(posedge clk) disable iff (!resetn)
        take && core_rd && core_addr inside {[`WIN_LO:`WIN_HI]} ##2 core_rdata_valid);
    c_page_write: cover property (@(posedge clk) disable iff (!resetn)
        take && !core_rd && core_addr == `PAGE_ADDR);
    c_nmi: cover property (@(posedge clk) disable iff (!resetn) nmi_request ##1 nmi_ack);

endmodule : data_space_map_rom_window

// ===== verification/mem_model.sv
`include "dspace_defs.svh"

module mem_model (
    input  wire logic [`PC_BITS-1:0] pm_read_addr,
    output logic      [7:0]          pm_read_data,
    input  wire logic [7:0]          slot_addr,
    output logic      [7:0]          slot_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Program memory pattern and peripheral answers, both pure functions of address
    assign pm_read_data = pm_read_addr[7:0] ^ {pm_read_addr[11:8], 4'ha};
    assign slot_rdata   = ~slot_addr;
endmodule : mem_model

// ===== verification/tb_top.sv
`include "dspace_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dspace_pkg::*;
    logic clk = 0, resetn = 0, core_rd = 0, core_wr = 0, core_bit_op = 0;
    logic [7:0] core_addr = 0, core_wdata = 0, core_rdata, slot_addr, slot_wdata, slot_rdata;
    logic [7:0] pm_read_data, ext_rd_data;
    logic core_rdata_valid, core_busy, slot_rd, slot_wr, nmi_request, core_restart, prog_mode;
    logic ext_rd_valid, pc_step = 0, pc_jump = 0, call_req = 0, ret_req = 0;
    logic nmi_pin_n = 1, nmi_ack = 0, reset_pin_n = 1, test_pin_high = 0, readout_protect = 0;
    logic ext_rd_req = 0;
    logic [11:0] jump_target = 0, ext_rd_addr = 0, pm_read_addr, prog_counter, pa;
    slot_t       slot_sel;
    logic [7:0]  got, pg, ofs;
    logic [8:0]  sw;
    logic [11:0] epc = 0;
    logic [11:0] stk [6] = '{default: 0};
    int bad_count = 0, comparisons = 0, seed = 32'hc5f6;
    localparam logic [7:0] adr [15] = '{8'h00, 8'h3f, 8'h80, 8'h81, 8'h82, 8'hc4, 8'hc6,
        8'hcc, 8'hce, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hff};
    localparam slot_t sl [15] = '{SLOT_BANK, SLOT_BANK, SLOT_IDX_X, SLOT_IDX_Y, SLOT_SHORT_V,
        SLOT_PORT_DIR, SLOT_PORT_DIR, SLOT_PORT_OPT, SLOT_PORT_OPT, SLOT_ADC_DATA,
        SLOT_ADC_CTRL, SLOT_TMR_PSC, SLOT_TMR_CNT, SLOT_TMR_SC, SLOT_ACC};

    always #20 clk = ~clk;

    data_space_map_rom_window dut_u (.clk(clk), .resetn(resetn), .core_rd(core_rd),
        .core_wr(core_wr), .core_bit_op(core_bit_op), .core_addr(core_addr),
        .core_wdata(core_wdata), .core_rdata(core_rdata), .core_rdata_valid(core_rdata_valid),
        .core_busy(core_busy), .slot_sel(slot_sel), .slot_addr(slot_addr),
        .slot_wdata(slot_wdata), .slot_rd(slot_rd), .slot_wr(slot_wr),
        .slot_rdata(slot_rdata), .pm_read_addr(pm_read_addr), .pm_read_data(pm_read_data),
        .pc_step(pc_step), .pc_jump(pc_jump), .call_req(call_req), .ret_req(ret_req),
        .jump_target(jump_target), .prog_counter(prog_counter), .nmi_pin_n(nmi_pin_n),
        .nmi_ack(nmi_ack), .nmi_request(nmi_request), .reset_pin_n(reset_pin_n),
        .core_restart(core_restart), .test_pin_high(test_pin_high), .prog_mode(prog_mode),
        .readout_protect(readout_protect), .ext_rd_req(ext_rd_req),
        .ext_rd_addr(ext_rd_addr), .ext_rd_data(ext_rd_data), .ext_rd_valid(ext_rd_valid));

    mem_model model_u (.pm_read_addr(pm_read_addr), .pm_read_data(pm_read_data),
        .slot_addr(slot_addr), .slot_rdata(slot_rdata));

    function automatic logic [7:0] pmv(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'ha};
    endfunction : pmv

    task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", name, e, g);
            bad_count++;
        end
    endtask : chk

    // One core access; pa holds the program address shown in the busy cycle
    task automatic acc(input logic rd, input logic bop, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        core_rd <= rd;
        core_wr <= !rd;
        core_bit_op <= bop;
        core_addr <= a;
        core_wdata <= d;
        @(posedge clk);
        core_rd <= 0;
        core_wr <= 0;
        #1 pa = pm_read_addr;
        sw = {slot_wr, slot_wdata};
        chk("busy", 1, core_busy);
        @(posedge clk);
        #1 got = core_rdata;
        if (rd) chk("valid", 1, core_rdata_valid);
    endtask : acc

    task automatic stop_test;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // Program flow inputs wander at random to exercise the counter and stack
    always @(posedge clk) begin
        if (resetn) {pc_step, pc_jump, call_req, ret_req, jump_target} <= 16'($random(seed));
    end

    // Reference counter and return stack, advanced on the same inputs as the design
    always @(posedge clk) begin
        if (resetn) chk("pc", epc, prog_counter);
        if (!resetn) begin
            epc <= 0;
            stk <= '{default: 0};
        end else if (core_restart) begin
            epc <= 0;
        end else begin
            if (call_req || pc_jump) epc <= jump_target;
            else if (ret_req) epc <= stk[0];
            else if (pc_step) epc <= epc + 12'h001;
            if (call_req) begin
                stk <= '{epc + 12'h001, stk[0], stk[1], stk[2], stk[3], stk[4]};
            end else if (ret_req) begin
                stk <= '{stk[1], stk[2], stk[3], stk[4], stk[5], 12'h000};
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        stop_test;
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        repeat (4) @(posedge clk);
        acc(0, 0, 8'hc9, 8'h28);
        acc(1, 0, 8'h59, 0);
        chk("pm_addr", 12'ha19, pa);
        chk("rdata", pmv(12'ha19), got);
        acc(0, 1, 8'hc9, 8'h3f);
        acc(1, 0, 8'h40, 0);
        chk("pm_addr", 12'ha00, pa);
        acc(1, 0, 8'hc9, 0);
        chk("page_read", 0, got);
        for (int i = 0; i < 8; i++) begin
            pg = (i == 0) ? 8'hff : 8'($random(seed));
            ofs = (i == 0) ? 8'h3f : 8'($random(seed)) & 8'h3f;
            acc(0, 0, 8'hc9, pg);
            acc(1, 0, 8'h40 + ofs, 0);
            chk("pm_addr", {pg[5:0], ofs[5:0]}, pa);
            chk("rdata", pmv({pg[5:0], ofs[5:0]}), got);
        end
        $display("test window done");
        for (int i = 0; i < 6; i++) begin
            ofs = 8'h84 + 8'(i == 0 ? 0 : i == 1 ? 59 : {$random(seed)} % 60);
            pg = 8'($random(seed));
            acc(0, 0, ofs, pg);
            acc(1, 0, ofs, 0);
            chk("ram", pg, got);
        end
        $display("test ram done");
        for (int i = 0; i < 15; i++) begin
            acc(1, 0, adr[i], 0);
            chk("slot", sl[i], slot_sel);
            chk("slot_data", 8'(~adr[i]), got);
            acc(0, 0, adr[i], adr[i]);
            chk("slot_wr", {1'b1, adr[i]}, sw);
        end
        $display("test decode done");
        @(posedge clk);
        nmi_pin_n <= 0;
        repeat (5) @(posedge clk);
        #1 chk("nmi", 1, nmi_request);
        @(posedge clk);
        nmi_ack <= 1;
        nmi_pin_n <= 1;
        @(posedge clk);
        nmi_ack <= 0;
        repeat (2) @(posedge clk);
        #1 chk("nmi_clear", 0, nmi_request);
        $display("test nmi done");
        @(posedge clk);
        reset_pin_n <= 0;
        test_pin_high <= 1;
        repeat (6) @(posedge clk);
        #1 chk("restart", 1, core_restart);
        reset_pin_n <= 1;
        repeat (6) @(posedge clk);
        test_pin_high <= 0;
        #1 chk("prog", 1, prog_mode);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            readout_protect <= p[0];
            ext_rd_req <= 1;
            ext_rd_addr <= 12'h5c3;
            @(posedge clk);
            ext_rd_req <= 0;
            @(posedge clk);
            #1 chk("ext_valid", 1, ext_rd_valid);
            chk("ext_data", p ? 8'h00 : pmv(12'h5c3), ext_rd_data);
            @(posedge clk);
        end
        $display("test program mode done");
        stop_test;
    end
endmodule : tb_top
